// *** serial_far_end.sv ***
`timescale 1ns/1ps
module serial_far_end (
    input wire hclk,
    output reg rx_serial_in,
    output reg rx_ext_clock_pin,
    output reg tx_ext_clock_pin
);
    // idle line marks; 1x clocks stand still outside frames
    initial begin
        rx_serial_in = 1'b1;
        rx_ext_clock_pin = 1'b0;
        tx_ext_clock_pin = 1'b0;
    end
    // one tick per bit, lsb first; tx only clocks the transmitter
    task bits(input [15:0] v, input integer n, input tx);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                rx_serial_in <= tx | v[i];
                repeat (2) @(posedge hclk);
                rx_ext_clock_pin <= !tx;
                tx_ext_clock_pin <= tx;
                repeat (3) @(posedge hclk);
                rx_ext_clock_pin <= 1'b0;
                tx_ext_clock_pin <= 1'b0;
                repeat (2) @(posedge hclk);
            end
            rx_serial_in <= 1'b1;
        end
    endtask
endmodule // serial_far_end

// *** tb_uart_channel_command_clock_status.sv ***
`timescale 1ns/1ps
module tb_uart_channel_command_clock_status;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg crystal_clock_in = 1'b0;
    reg mode_reg_access = 1'b0;
    reg ct_ready_pulse = 1'b0;
    reg partner_timeout_mode = 1'b0;
    reg partner_rx_push = 1'b0;
    reg [31:0] lows = 32'h0;
    reg [31:0] r;
    wire hready;
    wire [31:0] hrdata;
    wire rx_serial_in, rx_ext_clock_pin, tx_ext_clock_pin, tx_serial_out;
    wire request_send_out_low, timeout_mode, hresp;
    wire [1:0] mode_reg_pointer;
    integer n_mismatch = 0;
    integer check_count = 0;
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) crystal_clock_in <= ~crystal_clock_in;
    always @(posedge hclk) lows <= lows + !tx_serial_out;
    uart_channel_command_clock_status i_uart_channel_command_clock_status (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .crystal_clock_in(crystal_clock_in), .rx_serial_in(rx_serial_in),
        .rx_ext_clock_pin(rx_ext_clock_pin),
        .tx_ext_clock_pin(tx_ext_clock_pin), .tx_serial_out(tx_serial_out),
        .request_send_out_low(request_send_out_low),
        .mode_reg_access(mode_reg_access), .mode_reg_pointer(mode_reg_pointer),
        .ct_tick(1'b0), .ct_ready_pulse(ct_ready_pulse),
        .partner_timeout_mode(partner_timeout_mode),
        .partner_rx_push(partner_rx_push), .timeout_mode(timeout_mode),
        .ct_restart(), .ct_stop(), .ct_ready_clear(), .rx_push(),
        .counter_ready_flag(), .break_change_flag());
    serial_far_end i_serial_far_end (.hclk(hclk), .rx_serial_in(rx_serial_in),
        .rx_ext_clock_pin(rx_ext_clock_pin),
        .tx_ext_clock_pin(tx_ext_clock_pin));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task bus(input [7:0] a, input w, input [7:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {24'h0, a};
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            r = hrdata;
            chk(hresp, 32'h0);
            repeat (8) @(posedge hclk); // upper commands kept apart
        end
    endtask
    task rc(input [7:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 8'h0);
            chk(r, e);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(8'h04, 32'h0);
        rc(8'h40, 32'h0);
        bus(8'h00, 1'b1, 8'h80);
        chk(request_send_out_low, 32'h0);
        bus(8'h00, 1'b1, 8'h90);
        chk(request_send_out_low, 32'h1);
        mode_reg_access <= 1'b1;
        repeat (2) @(posedge hclk);
        mode_reg_access <= 1'b0;
        bus(8'h00, 1'b1, 8'hb0);
        chk(mode_reg_pointer, 32'h0);
        ct_ready_pulse <= 1'b1;
        @(posedge hclk);
        ct_ready_pulse <= 1'b0;
        rc(8'h10, 32'h08);
        bus(8'h00, 1'b1, 8'ha0);
        chk(timeout_mode, 32'h1);
        rc(8'h10, 32'h00);
        ct_ready_pulse <= 1'b1;
        @(posedge hclk);
        ct_ready_pulse <= 1'b0;
        bus(8'h00, 1'b1, 8'hc0);
        rc(8'h10, 32'h08);
        bus(8'h00, 1'b1, 8'ha0);
        partner_timeout_mode <= 1'b1;
        partner_rx_push <= 1'b1;
        @(posedge hclk);
        partner_rx_push <= 1'b0;
        $display("commands test done");
        bus(8'h04, 1'b1, 8'hff);
        bus(8'h00, 1'b1, 8'h01);
        i_serial_far_end.bits(16'h02b4, 10, 1'b0);
        bus(8'h00, 1'b1, 8'h02);
        rc(8'h08, 32'h01);
        rc(8'h18, 32'h5a);
        bus(8'h00, 1'b1, 8'hd1);
        i_serial_far_end.bits(16'h0000, 14, 1'b0);
        rc(8'h10, 32'h04);
        rc(8'h08, 32'hc1);
        rc(8'h18, 32'h00);
        rc(8'h08, 32'hc0);
        bus(8'h00, 1'b1, 8'h50);
        i_serial_far_end.bits(16'hffff, 3, 1'b0);
        rc(8'h10, 32'h04);
        bus(8'h00, 1'b1, 8'h20);
        rc(8'h08, 32'h00);
        $display("receive test done");
        bus(8'h00, 1'b1, 8'h04);
        rc(8'h08, 32'h0c);
        bus(8'h14, 1'b1, 8'ha5);
        chk(tx_serial_out, 32'h0);
        bus(8'h00, 1'b1, 8'h08);
        rc(8'h08, 32'h00);
        bus(8'h14, 1'b1, 8'h33);
        i_serial_far_end.bits(16'h0, 12, 1'b1);
        chk(tx_serial_out, 32'h1);
        r = lows;
        i_serial_far_end.bits(16'h0, 12, 1'b1);
        chk(lows, r);
        $display("transmit test done");
        finish_test;
    end
endmodule // tb_uart_channel_command_clock_status

// *** uart_channel_command_clock_status.v ***
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "uart_channel_regs.vh"

// Notes on behaviour
// - code 1001 drives request-to-send high
// - timeout mode restarts timer per received char
// - timeout entry: counter mode, stop, clear ready
// - both in timeout: either receiver restarts
// - code 1011 points mode pointer at zero
// - code 1100 releases timer, no stop/clear
// - code 1101 accumulates errors on queue entry
// - block errors cleared by receiver reset or error reset
// - receiver 16x except 1111 external pin
// - transmitter 1110 pin 16x, 1111 pin 1x
// - rates derived from 3.6864 MHz reference
// - tx disable clears flags, finishes queued chars
// - no tx queue writes while disabled/pending
// - tx enable sets ready and empty flags
// - rx disable drops partial, keeps queue, status
// - wake-up mode keeps receiver running
// - rx enable forces start-bit hunt
// - all-zero char without stop flags break
// - after break, wait marking two samples
// - break start and end set change flag
// - mid-character break needs next char low
module uart_channel_command_clock_status (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire crystal_clock_in,
    input wire rx_serial_in,
    input wire rx_ext_clock_pin,
    input wire tx_ext_clock_pin,
    output wire tx_serial_out,
    output reg request_send_out_low,
    input wire mode_reg_access,
    output reg [1:0] mode_reg_pointer,
    input wire ct_tick,
    input wire ct_ready_pulse,
    input wire partner_timeout_mode,
    input wire partner_rx_push,
    output reg timeout_mode,
    output reg ct_restart,
    output reg ct_stop,
    output reg ct_ready_clear,
    output reg rx_push,
    output reg counter_ready_flag,
    output reg break_change_flag
);
    localparam RX_IDLE = 3'd0;
    localparam RX_START = 3'd1;
    localparam RX_DATA = 3'd2;
    localparam RX_STOP = 3'd3;
    localparam RX_BREAK = 3'd4;

    reg wr_en;
    reg [7:0] wr_addr;
    reg [7:0] baud_clock_select;
    reg [7:0] auxiliary_control;
    reg block_mode;
    reg xtal_d, rx_pin_d, tx_pin_d;
    reg [12:0] rx_div_cnt, tx_div_cnt;
    reg rx_enable;
    reg [2:0] rx_state;
    reg [3:0] rx_phase;
    reg [2:0] rx_bits;
    reg [7:0] rx_shift;
    reg rx_zero, brk_high, brk_end;
    reg [7:0] rx_push_data;
    reg rx_push_fe, rx_push_brk;
    reg [9:0] rx_mem [0:`RX_DEPTH-1];
    reg [2:0] rx_wr_ptr, rx_rd_ptr;
    reg [3:0] rx_count;
    reg acc_brk, acc_fe, overrun;
    reg tx_enable, tx_pending, tx_hold_full, tx_busy;
    reg tx_ready_flag, tx_empty_flag;
    reg [7:0] tx_hold;
    reg [9:0] tx_shift;
    reg [3:0] tx_left, tx_phase;
    reg [31:0] rd_mux;

    wire [3:0] cmd = hwdata[7:4];
    wire cmd_wr = wr_en & (wr_addr == `OFF_CHANNEL_COMMAND);
    wire rd_take = hsel & htrans[1] & ~hwrite & hready;
    wire set2 = auxiliary_control[`AUX_RATE_SET];
    wire wake = auxiliary_control[`AUX_WAKEUP];
    wire [3:0] rx_code = baud_clock_select[7:4];
    wire [3:0] tx_code = baud_clock_select[3:0];
    wire xtal_edge = crystal_clock_in & ~xtal_d;
    wire rx_pin_rise = rx_ext_clock_pin & ~rx_pin_d;
    wire tx_pin_rise = tx_ext_clock_pin & ~tx_pin_d;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    function [31:0] rate_div;
        input [3:0] code;
        input alt;
        begin
            case (code)
                4'h0: rate_div = alt ? `BAUD_DIV(750) : `BAUD_DIV(500);
                4'h1: rate_div = `BAUD_DIV(1100);
                4'h2: rate_div = alt ? `BAUD_DIV(384000) : `BAUD_DIV(1345);
                4'h3: rate_div = alt ? `BAUD_DIV(1500) : `BAUD_DIV(2000);
                4'h4: rate_div = `BAUD_DIV(3000);
                4'h5: rate_div = `BAUD_DIV(6000);
                4'h6: rate_div = `BAUD_DIV(12000);
                4'h7: rate_div = alt ? `BAUD_DIV(20000) : `BAUD_DIV(10500);
                4'h8: rate_div = `BAUD_DIV(24000);
                4'h9: rate_div = `BAUD_DIV(48000);
                4'ha: rate_div = alt ? `BAUD_DIV(18000) : `BAUD_DIV(72000);
                4'hb: rate_div = `BAUD_DIV(96000);
                4'hc: rate_div = alt ? `BAUD_DIV(192000) : `BAUD_DIV(384000);
                default: rate_div = 32'd1;
            endcase
        end
    endfunction

    wire [31:0] rx_div = rate_div(rx_code, set2);
    wire [31:0] tx_div = rate_div(tx_code, set2);
    wire rx_brg = xtal_edge & ({19'd0, rx_div_cnt} >= rx_div - 32'd1);
    wire tx_brg = xtal_edge & ({19'd0, tx_div_cnt} >= tx_div - 32'd1);

    // external pin on 1110 and 1111; 1110 is the pin taken as 16x
    wire rx_tick = (rx_code == `SEL_TIMER) ? ct_tick :
        (rx_code == `SEL_EXT1 || rx_code == `SEL_EXT16) ? rx_pin_rise :
        rx_brg;
    wire rx_x1 = (rx_code == `SEL_EXT1);
    wire tx_tick = (tx_code == `SEL_TIMER) ? ct_tick :
        (tx_code == `SEL_EXT1 || tx_code == `SEL_EXT16) ? tx_pin_rise :
        tx_brg;
    wire tx_x1 = (tx_code == `SEL_EXT1);
    wire rx_sample = rx_tick & (rx_x1 | (rx_phase == 4'h7));
    wire tx_bit = tx_tick & (tx_x1 | (tx_phase == 4'hf));
    wire rx_on = rx_enable | wake;
    wire [2:0] rx_last = {1'b0, auxiliary_control[1:0]} + 3'd4;
    wire [2:0] len_gap = 3'd3 - {1'b0, auxiliary_control[1:0]};
    wire [7:0] len_mask = 8'hff >> len_gap;
    wire rx_pop = rd_take & (haddr[7:0] == `OFF_RX_DATA) &
        (rx_count != 4'd0);
    wire rx_full = (rx_count == `RX_DEPTH);
    wire rx_rst = cmd_wr & (cmd == `CMD_RX_RESET);
    wire tx_rst = cmd_wr & (cmd == `CMD_TX_RESET);
    wire err_rst = cmd_wr & (cmd == `CMD_ERR_RESET);
    wire tx_accept = wr_en & (wr_addr == `OFF_TX_DATA) & tx_enable &
        ~tx_pending & ~tx_hold_full;
    wire tx_load = ~tx_busy & tx_hold_full;
    wire tx_done = tx_busy & tx_bit & (tx_left == 4'd1);
    wire [9:0] rx_head = rx_mem[rx_rd_ptr];
    wire head_brk = (rx_count != 4'd0) & rx_head[9];
    wire head_fe = (rx_count != 4'd0) & rx_head[8];
    wire [7:0] line_status = {block_mode ? acc_brk : head_brk,
        block_mode ? acc_fe : head_fe, 1'b0, overrun, tx_empty_flag,
        tx_ready_flag, rx_full, rx_count != 4'd0};

    always @* begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            `OFF_CHANNEL_LINE_STATUS: rd_mux = {24'h0, line_status};
            `OFF_AUXILIARY_CONTROL: rd_mux = {24'h0, auxiliary_control};
            `OFF_INTERRUPT_STATUS: rd_mux = {28'h0, counter_ready_flag,
                break_change_flag, 2'b00};
            `OFF_RX_DATA: rd_mux = {24'h0, rx_count != 4'd0 ?
                rx_head[7:0] : 8'h00};
            `OFF_CHANNEL_MODE: rd_mux = {25'h0, mode_reg_pointer,
                tx_pending, rx_enable, tx_enable, block_mode, timeout_mode};
            default: rd_mux = 32'h0;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
            baud_clock_select <= `CSR_RESET;
            auxiliary_control <= `AUX_RESET;
        end else begin
            if (hready) begin
                wr_en <= hsel & htrans[1] & hwrite;
                wr_addr <= haddr[7:0];
            end
            if (rd_take) begin
                hrdata <= rd_mux;
            end
            if (wr_en && wr_addr == `OFF_BAUD_CLOCK_SELECT) begin
                baud_clock_select <= hwdata[7:0];
            end
            if (wr_en && wr_addr == `OFF_AUXILIARY_CONTROL) begin
                auxiliary_control <= hwdata[7:0];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_d <= 1'b0;
            rx_pin_d <= 1'b0;
            tx_pin_d <= 1'b0;
            rx_div_cnt <= 13'd0;
            tx_div_cnt <= 13'd0;
        end else begin
            xtal_d <= crystal_clock_in;
            rx_pin_d <= rx_ext_clock_pin;
            tx_pin_d <= tx_ext_clock_pin;
            if (xtal_edge) begin
                rx_div_cnt <= rx_brg ? 13'd0 : rx_div_cnt + 13'd1;
                tx_div_cnt <= tx_brg ? 13'd0 : tx_div_cnt + 13'd1;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request_send_out_low <= 1'b1;
            mode_reg_pointer <= 2'h0;
            timeout_mode <= 1'b0;
            block_mode <= 1'b0;
            ct_restart <= 1'b0;
            ct_stop <= 1'b0;
            ct_ready_clear <= 1'b0;
            counter_ready_flag <= 1'b0;
            break_change_flag <= 1'b0;
        end else begin
            ct_stop <= cmd_wr & (cmd == `CMD_TIMEOUT_ON);
            ct_ready_clear <= cmd_wr & (cmd == `CMD_TIMEOUT_ON);
            ct_restart <= timeout_mode & (rx_push |
                (partner_timeout_mode & partner_rx_push));
            if (cmd_wr && cmd == `CMD_RTS_ASSERT) begin
                request_send_out_low <= 1'b0;
            end else if (cmd_wr && cmd == `CMD_RTS_NEGATE) begin
                request_send_out_low <= 1'b1;
            end
            if (cmd_wr && cmd == `CMD_MR_PTR_ZERO) begin
                mode_reg_pointer <= 2'h0;
            end else if (cmd_wr && cmd == `CMD_MR_PTR_ONE) begin
                mode_reg_pointer <= `MR_PTR_ONE;
            end else if (mode_reg_access &&
                         mode_reg_pointer != `MR_PTR_LAST) begin
                mode_reg_pointer <= mode_reg_pointer + 2'h1;
            end
            if (cmd_wr && cmd == `CMD_TIMEOUT_ON) begin
                timeout_mode <= 1'b1;
            end else if (cmd_wr && cmd == `CMD_TIMEOUT_OFF) begin
                timeout_mode <= 1'b0;
            end
            if (rx_rst) begin
                block_mode <= 1'b0;
            end else if (cmd_wr && cmd == `CMD_BLOCK_ERR) begin
                block_mode <= 1'b1;
            end
            // a new event beats a clear in the same cycle
            if (ct_ready_pulse) begin
                counter_ready_flag <= 1'b1;
            end else if (cmd_wr && cmd == `CMD_TIMEOUT_ON) begin
                counter_ready_flag <= 1'b0;
            end
            if ((rx_push & rx_push_brk) | brk_end) begin
                break_change_flag <= 1'b1;
            end else if (cmd_wr && cmd == `CMD_BRK_CHG_RESET) begin
                break_change_flag <= 1'b0;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_enable <= 1'b0;
            rx_state <= RX_IDLE;
            rx_phase <= 4'h0;
            rx_bits <= 3'd0;
            rx_shift <= 8'h00;
            rx_zero <= 1'b0;
            brk_high <= 1'b0;
            brk_end <= 1'b0;
            rx_push <= 1'b0;
            rx_push_data <= 8'h00;
            rx_push_fe <= 1'b0;
            rx_push_brk <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            brk_end <= 1'b0;
            if (rx_tick) begin
                rx_phase <= rx_phase + 4'h1;
            end
            if (rx_rst) begin
                rx_enable <= 1'b0;
                rx_state <= RX_IDLE;
            end else if (cmd_wr && hwdata[`CMD_RX_DISABLE]) begin
                rx_enable <= 1'b0;
                if (!wake) begin
                    rx_state <= RX_IDLE;
                end
            end else if (cmd_wr && hwdata[`CMD_RX_ENABLE]) begin
                rx_enable <= 1'b1;
                if (!wake) begin
                    rx_state <= RX_IDLE;
                end
            end else if (rx_on) begin
                case (rx_state)
                    RX_IDLE: begin
                        if (rx_tick && !rx_serial_in) begin
                            rx_phase <= 4'h0;
                            rx_bits <= 3'd0;
                            rx_zero <= 1'b1;
                            rx_state <= rx_x1 ? RX_DATA : RX_START;
                        end
                    end
                    RX_START: begin
                        if (rx_sample) begin
                            rx_state <= rx_serial_in ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_sample) begin
                            rx_shift <= {rx_serial_in, rx_shift[7:1]};
                            rx_zero <= rx_zero & ~rx_serial_in;
                            rx_bits <= rx_bits + 3'd1;
                            if (rx_bits == rx_last) begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (rx_sample) begin
                            rx_push <= 1'b1;
                            rx_push_data <= rx_shift >> len_gap;
                            rx_push_fe <= ~rx_serial_in;
                            // a break that starts mid-character only
                            // shows once a whole later character is zero
                            rx_push_brk <= ~rx_serial_in & rx_zero;
                            brk_high <= 1'b0;
                            rx_state <= (~rx_serial_in & rx_zero) ?
                                RX_BREAK : RX_IDLE;
                        end
                    end
                    RX_BREAK: begin
                        if (rx_sample) begin
                            brk_high <= rx_serial_in;
                            if (rx_serial_in && brk_high) begin
                                brk_end <= 1'b1;
                                rx_state <= RX_IDLE;
                            end
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_wr_ptr <= 3'd0;
            rx_rd_ptr <= 3'd0;
            rx_count <= 4'd0;
            acc_brk <= 1'b0;
            acc_fe <= 1'b0;
            overrun <= 1'b0;
        end else if (rx_rst) begin
            rx_wr_ptr <= 3'd0;
            rx_rd_ptr <= 3'd0;
            rx_count <= 4'd0;
            acc_brk <= 1'b0;
            acc_fe <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (rx_push && !rx_full) begin
                rx_wr_ptr <= rx_wr_ptr + 3'd1;
            end
            if (rx_pop) begin
                rx_rd_ptr <= rx_rd_ptr + 3'd1;
            end
            if ((rx_push && !rx_full) && !rx_pop) begin
                rx_count <= rx_count + 4'd1;
            end else if (!(rx_push && !rx_full) && rx_pop) begin
                rx_count <= rx_count - 4'd1;
            end
            // set on entry beats the error reset command
            if (rx_push && !rx_full && block_mode) begin
                acc_brk <= acc_brk | rx_push_brk;
                acc_fe <= acc_fe | rx_push_fe;
            end else if (err_rst) begin
                acc_brk <= 1'b0;
                acc_fe <= 1'b0;
            end
            if (rx_push && rx_full) begin
                overrun <= 1'b1;
            end else if (err_rst) begin
                overrun <= 1'b0;
            end
        end
    end

    always @(posedge hclk) begin
        if (rx_push && !rx_full) begin
            rx_mem[rx_wr_ptr] <= {rx_push_brk, rx_push_fe, rx_push_data};
        end
    end

    assign tx_serial_out = tx_shift[0];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_enable <= 1'b0;
            tx_pending <= 1'b0;
            tx_hold_full <= 1'b0;
            tx_hold <= 8'h00;
            tx_busy <= 1'b0;
            tx_shift <= 10'h3ff;
            tx_left <= 4'd0;
            tx_phase <= 4'h0;
            tx_ready_flag <= 1'b0;
            tx_empty_flag <= 1'b0;
        end else if (tx_rst) begin
            tx_enable <= 1'b0;
            tx_pending <= 1'b0;
            tx_hold_full <= 1'b0;
            tx_busy <= 1'b0;
            tx_shift <= 10'h3ff;
            tx_ready_flag <= 1'b0;
            tx_empty_flag <= 1'b0;
        end else begin
            if (tx_tick) begin
                tx_phase <= tx_phase + 4'h1;
            end
            if (tx_accept) begin
                tx_hold <= hwdata[7:0];
                tx_hold_full <= 1'b1;
                tx_ready_flag <= 1'b0;
                tx_empty_flag <= 1'b0;
            end else if (tx_load) begin
                tx_hold_full <= 1'b0;
                tx_busy <= 1'b1;
                tx_phase <= 4'h0;
                tx_left <= {2'b00, auxiliary_control[1:0]} + 4'd7;
                tx_shift <= {1'b1, tx_hold | ~len_mask, 1'b0};
                tx_ready_flag <= tx_enable & ~tx_pending;
            end else if (tx_bit && tx_busy) begin
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_left <= tx_left - 4'd1;
                if (tx_done) begin
                    tx_busy <= 1'b0;
                    tx_empty_flag <= tx_enable & ~tx_pending;
                    if (tx_pending) begin
                        tx_enable <= 1'b0;
                        tx_pending <= 1'b0;
                    end
                end
            end
            if (cmd_wr && hwdata[`CMD_TX_DISABLE]) begin
                tx_ready_flag <= 1'b0;
                tx_empty_flag <= 1'b0;
                if (tx_busy || tx_hold_full) begin
                    tx_pending <= tx_enable;
                end else begin
                    tx_enable <= 1'b0;
                end
            end else if (cmd_wr && hwdata[`CMD_TX_ENABLE]) begin
                tx_enable <= 1'b1;
                tx_pending <= 1'b0;
                tx_ready_flag <= 1'b1;
                tx_empty_flag <= 1'b1;
            end
        end
    end
endmodule // uart_channel_command_clock_status

// *** uart_channel_command_clock_status_asserts.sv ***
`timescale 1ns/1ps
module cmd_status_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hwdata,
    input wire request_send_out_low,
    input wire mode_reg_access,
    input wire [1:0] mode_reg_pointer,
    input wire rx_push,
    input wire timeout_mode,
    input wire partner_timeout_mode,
    input wire partner_rx_push,
    input wire ct_restart,
    input wire ct_stop,
    input wire ct_ready_clear,
    input wire ct_ready_pulse,
    input wire counter_ready_flag
);
    reg cmd_dp;
    wire [3:0] code = cmd_dp ? hwdata[7:4] : 4'h0;
    // data phase of a command write, when hwdata is valid
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_dp <= 1'b0;
        end else begin
            cmd_dp <= hsel & htrans[1] & hready & hwrite & ~|haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rts; code == 4'h9 |=> request_send_out_low; endproperty
    a_rts: assert property (p_rts) else $error("rts not negated");
    property p_ton; code == 4'ha |=>
        timeout_mode && ct_stop && ct_ready_clear; endproperty
    a_ton: assert property (p_ton) else $error("timeout entry wrong");
    property p_tclr; code == 4'ha && !ct_ready_pulse |=>
        !counter_ready_flag; endproperty
    a_tclr: assert property (p_tclr) else $error("ready not cleared");
    property p_toff; code == 4'hc |=>
        !timeout_mode && !ct_stop && !ct_ready_clear; endproperty
    a_toff: assert property (p_toff) else $error("timeout exit wrong");
    property p_keep; counter_ready_flag && code != 4'ha |=>
        counter_ready_flag; endproperty
    a_keep: assert property (p_keep) else $error("ready lost");
    property p_ptr; code == 4'hb && !mode_reg_access |=>
        mode_reg_pointer == 2'h0; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not zero");
    property p_rst; rx_push && timeout_mode |=> ct_restart; endproperty
    a_rst: assert property (p_rst) else $error("no restart");
    property p_both; timeout_mode && partner_timeout_mode &&
        partner_rx_push |=> ct_restart; endproperty
    a_both: assert property (p_both) else $error("no shared restart");
endmodule // cmd_status_chk
bind uart_channel_command_clock_status cmd_status_chk i_cmd_status_chk (.*);

// *** uart_channel_regs.vh ***
`ifndef UART_CHANNEL_REGS_VH
`define UART_CHANNEL_REGS_VH

// byte offsets on the bus, decoded from haddr[7:0]
`define OFF_CHANNEL_COMMAND 8'h00
`define OFF_BAUD_CLOCK_SELECT 8'h04
`define OFF_CHANNEL_LINE_STATUS 8'h08
`define OFF_AUXILIARY_CONTROL 8'h0c
`define OFF_INTERRUPT_STATUS 8'h10
`define OFF_TX_DATA 8'h14
`define OFF_RX_DATA 8'h18
`define OFF_CHANNEL_MODE 8'h1c

// upper command field codes
`define CMD_MR_PTR_ONE 4'h1
`define CMD_RX_RESET 4'h2
`define CMD_TX_RESET 4'h3
`define CMD_ERR_RESET 4'h4
`define CMD_BRK_CHG_RESET 4'h5
`define CMD_RTS_ASSERT 4'h8
`define CMD_RTS_NEGATE 4'h9
`define CMD_TIMEOUT_ON 4'ha
`define CMD_MR_PTR_ZERO 4'hb
`define CMD_TIMEOUT_OFF 4'hc
`define CMD_BLOCK_ERR 4'hd

// lower command field bit positions
`define CMD_TX_DISABLE 3
`define CMD_TX_ENABLE 2
`define CMD_RX_DISABLE 1
`define CMD_RX_ENABLE 0

// clock select special codes
`define SEL_TIMER 4'hd
`define SEL_EXT16 4'he
`define SEL_EXT1 4'hf

// auxiliary control fields and register reset values
`define AUX_RATE_SET 7
`define AUX_WAKEUP 2
`define AUX_RESET 8'h03
`define CSR_RESET 8'hbb

// status bit positions
`define SR_BREAK 7
`define SR_FRAME 6
`define ISR_COUNTER_READY 3
`define ISR_BREAK_CHANGE 2

`define RX_DEPTH 8
`define MR_PTR_ONE 2'h1
`define MR_PTR_LAST 2'h2
`define CMD_SPACING_EDGES 3

// reference clock and 16x divider, rate given in tenths of baud
`define XTAL_HZ 3686400
`define BAUD_DIV(r10) ((`XTAL_HZ * 10) / (16 * (r10)))

`endif
